// [rtl/tsr_pkg.sv]
// constants, register map and carrier types of the temperature result register bank
// assumes a byte-level bus front end and a conversion engine on the same core_clk
`default_nettype none
package tsr_pkg;
  // ****************************************************************
  // register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_LOCAL_RESULT   = 8'h00;
  localparam logic [7:0] ADDR_REMOTE1_HIGH   = 8'h01;
  localparam logic [7:0] ADDR_CONFIG1_READ   = 8'h03;
  localparam logic [7:0] ADDR_CONFIG1_WRITE  = 8'h09;
  localparam logic [7:0] ADDR_REMOTE1_LOW    = 8'h10;
  localparam logic [7:0] ADDR_CONFIG2_LOCK   = 8'h24;
  localparam logic [7:0] ADDR_REMOTE2_HIGH   = 8'h30;
  localparam logic [7:0] ADDR_REMOTE2_LOW    = 8'h33;
  // ****************************************************************
  // reset values and field positions
  // ****************************************************************
  localparam logic [7:0] RESULT_RESET        = 8'h00;
  localparam logic [7:0] POINTER_RESET       = 8'h00;
  localparam logic [7:0] CONFIG1_RESET       = 8'h00;
  localparam logic [7:0] UNMAPPED_READ       = 8'h00;
  localparam int         LOCK_BIT            = 7;
  // ****************************************************************
  // encoding constants (whole degrees)
  // ****************************************************************
  localparam logic signed [11:0] EXT_OFFSET  = 12'sh040;
  localparam logic signed [11:0] DEF_MAX     = 12'sh07f;
  localparam logic signed [11:0] EXT_MAX     = 12'sh0ff;
  // ****************************************************************
  // conversion channel codes
  // ****************************************************************
  localparam logic [1:0] CH_LOCAL            = 2'h0;
  localparam logic [1:0] CH_REMOTE1          = 2'h1;
  localparam logic [1:0] CH_REMOTE2          = 2'h2;
  // ****************************************************************
  // carriers
  // ****************************************************************
  // first configuration register, msb first
  typedef struct packed {
    logic alarm_mask_all;            // bit 7
    logic standby_select;            // bit 6
    logic pin_function_select;       // bit 5
    logic reserved;                  // bit 4
    logic remote_view_select;        // bit 3
    logic range_select;              // bit 2
    logic first_remote_alarm_mask;   // bit 1
    logic second_remote_alarm_mask;  // bit 0
  } tsr_cfg1_s;
  // one result from the conversion engine, signed quarter degrees
  typedef struct packed {
    logic               valid;
    logic [1:0]         channel;
    logic signed [11:0] quarter_deg;
  } tsr_conv_s;
  // alarm requests from the limit comparators
  typedef struct packed {
    logic local_alarm;
    logic remote1_alarm;
    logic remote2_alarm;
    logic thermal_limit;
    logic high_limit;
  } tsr_alarm_s;
endpackage
`default_nettype wire

// [rtl/tsr_regbank.sv]
// register bank of a three channel temperature monitor: pointer, results, configuration
// assumes a byte-level bus front end on core_clk that flags first write byte,
// read strobes, stop and repeated start; conversions and alarms arrive on core_clk
`default_nettype none
module tsr_regbank
  import tsr_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // byte bus from the protocol front end
  input  wire logic       bus_wr_valid,
  input  wire logic       bus_wr_first,
  input  wire logic [7:0] bus_wr_data,
  input  wire logic       bus_rd_req,
  input  wire logic       bus_stop,
  input  wire logic       bus_rstart,
  output logic      [7:0] bus_rd_data_r,
  output logic            bus_rd_valid_r,
  // conversion engine
  input  wire tsr_conv_s  conv_in,
  output logic            conv_halt_r,
  output logic            range_ext_r,
  // alarm requests and pins, active low outputs
  input  wire tsr_alarm_s alarm_in,
  output logic            alarm_pin_n_r,
  output logic            thermal_limit_output_n_r
);
  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]  ptr_r;                  // register pointer
  tsr_cfg1_s   cfg1_r;                 // first configuration register
  logic        lock_r;                 // lock bit, sticky until reset
  logic [7:0]  local_r;                // local result
  logic [7:0]  hi_r     [2];           // remote high bytes, index 0 = remote one
  logic [7:0]  lo_r     [2];           // remote low bytes
  logic [7:0]  pend_hi_r[2];           // high byte held back while frozen
  logic [1:0]  pend_v_r;               // held-back byte waiting
  logic [1:0]  freeze_r;               // high byte frozen
  logic [1:0]  arm_r;                  // low byte read, freeze on stop
  // ****************************************************************
  // decode helpers
  // ****************************************************************
  logic        data_wr;                // second byte of a write
  logic [15:0] enc;                    // encoded conversion
  logic        conv_ok;                // conversion accepted
  logic        view2;                  // remote one addresses show remote two
  logic [1:0]  rd_lo;                  // low byte read, per channel
  logic [1:0]  rd_hi;                  // high byte read, per channel
  logic [1:0]  conv_rem;               // conversion for a remote channel
  logic [7:0]  rd_mux;                 // byte addressed by the pointer

  // encode quarter degrees into high and low bytes
  function automatic logic [15:0] tsr_encode(input logic signed [11:0] q,
                                              input logic               ext);
    logic signed [11:0] deg;
    logic signed [11:0] top;
    deg = (q >>> 2) + (ext ? EXT_OFFSET : 12'sh000);
    top = ext ? EXT_MAX : DEF_MAX;
    if (deg < 12'sh000)
      return 16'h0000;
    else if (deg > top)
      return {top[7:0], 8'h00};
    else
      return {deg[7:0], q[1:0], 6'h00};
  endfunction

  assign data_wr  = bus_wr_valid && !bus_wr_first;
  // standby drops conversions; encoding follows the range bit now
  assign conv_ok  = conv_in.valid && !cfg1_r.standby_select;
  assign enc      = tsr_encode(conv_in.quarter_deg, cfg1_r.range_select);
  assign view2    = cfg1_r.remote_view_select;
  assign conv_rem = {conv_ok && conv_in.channel == CH_REMOTE2,
                     conv_ok && conv_in.channel == CH_REMOTE1};
  // physical channel touched by a read, view bit folded in
  assign rd_lo[0] = bus_rd_req && ptr_r == ADDR_REMOTE1_LOW && !view2;
  assign rd_lo[1] = bus_rd_req && ((ptr_r == ADDR_REMOTE1_LOW && view2)
                                   || ptr_r == ADDR_REMOTE2_LOW);
  assign rd_hi[0] = bus_rd_req && ptr_r == ADDR_REMOTE1_HIGH && !view2;
  assign rd_hi[1] = bus_rd_req && ((ptr_r == ADDR_REMOTE1_HIGH && view2)
                                   || ptr_r == ADDR_REMOTE2_HIGH);

  // read multiplexer over the pointer
  always_comb
  begin
    case (ptr_r)
      ADDR_LOCAL_RESULT: rd_mux = local_r;
      ADDR_REMOTE1_HIGH: rd_mux = view2 ? hi_r[1] : hi_r[0];
      ADDR_REMOTE1_LOW:  rd_mux = view2 ? lo_r[1] : lo_r[0];
      ADDR_CONFIG1_READ: rd_mux = cfg1_r;
      ADDR_CONFIG2_LOCK: rd_mux = {lock_r, 7'h00};
      ADDR_REMOTE2_HIGH: rd_mux = hi_r[1];
      ADDR_REMOTE2_LOW:  rd_mux = lo_r[1];
      default:           rd_mux = UNMAPPED_READ;
    endcase
  end

  // ****************************************************************
  // pointer
  // ****************************************************************
  // first byte of any write lands here, never in an addressed register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ptr_r <= POINTER_RESET;
    else if (bus_wr_valid && bus_wr_first)
      ptr_r <= bus_wr_data;
  end

  // ****************************************************************
  // configuration and lock
  // ****************************************************************
  // config one takes writes only at its write address and only unlocked
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      cfg1_r <= CONFIG1_RESET;
    else if (data_wr && ptr_r == ADDR_CONFIG1_WRITE && !lock_r)
      cfg1_r <= bus_wr_data;
  end

  // lock sets once and clears only at reset
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      lock_r <= 1'b0;
    else if (data_wr && ptr_r == ADDR_CONFIG2_LOCK && bus_wr_data[LOCK_BIT])
      lock_r <= 1'b1;
  end

  // ****************************************************************
  // results
  // ****************************************************************
  // local result, written by conversions only; bus writes do not reach it
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      local_r <= RESULT_RESET;
    else if (conv_ok && conv_in.channel == CH_LOCAL)
      local_r <= enc[15:8];
  end

  // remote results, one loop per physical channel
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 2; i++)
      begin
        hi_r[i]      <= RESULT_RESET;
        lo_r[i]      <= RESULT_RESET;
        pend_hi_r[i] <= RESULT_RESET;
      end
      pend_v_r <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (conv_rem[i])
        begin
          lo_r[i] <= enc[7:0];
          // frozen high byte keeps its value; the new one waits
          if (freeze_r[i] && !rd_hi[i])
          begin
            pend_hi_r[i] <= enc[15:8];
            pend_v_r[i]  <= 1'b1;
          end
          else
          begin
            hi_r[i]     <= enc[15:8];
            pend_v_r[i] <= 1'b0;
          end
        end
        else if (rd_hi[i] && pend_v_r[i])
        begin
          // high byte read: release the waiting value
          hi_r[i]     <= pend_hi_r[i];
          pend_v_r[i] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // low-then-high read freeze
  // ****************************************************************
  // low read arms; a stop freezes; a repeated start disarms; high read frees
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      arm_r    <= 2'h0;
      freeze_r <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (rd_lo[i])
          arm_r[i] <= 1'b1;
        else if (bus_stop || bus_rstart || rd_hi[i])
          arm_r[i] <= 1'b0;
        if (bus_stop && arm_r[i])
          freeze_r[i] <= 1'b1;
        else if (rd_hi[i])
          freeze_r[i] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // bus read answer
  // ****************************************************************
  // answer one cycle after the strobe, held until the next strobe
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_rd_data_r  <= 8'h00;
      bus_rd_valid_r <= 1'b0;
    end
    else
    begin
      bus_rd_valid_r <= bus_rd_req;
      if (bus_rd_req)
        bus_rd_data_r <= rd_mux;
    end
  end

  // ****************************************************************
  // status toward conversion engine and pins
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      conv_halt_r <= 1'b0;
      range_ext_r <= 1'b0;
    end
    else
    begin
      conv_halt_r <= cfg1_r.standby_select;
      range_ext_r <= cfg1_r.range_select;
    end
  end

  // dual purpose pin and thermal output, inactive high in standby
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      alarm_pin_n_r            <= 1'b1;
      thermal_limit_output_n_r <= 1'b1;
    end
    else if (cfg1_r.standby_select)
    begin
      alarm_pin_n_r            <= 1'b1;
      thermal_limit_output_n_r <= 1'b1;
    end
    else
    begin
      thermal_limit_output_n_r <= !alarm_in.thermal_limit;
      if (cfg1_r.pin_function_select)
        alarm_pin_n_r <= !alarm_in.high_limit;
      else
        alarm_pin_n_r <= !(!cfg1_r.alarm_mask_all
          && (alarm_in.local_alarm
              || (alarm_in.remote1_alarm && !cfg1_r.first_remote_alarm_mask)
              || (alarm_in.remote2_alarm && !cfg1_r.second_remote_alarm_mask)));
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_ptr_load: assert property (
    bus_wr_valid && bus_wr_first |=> ptr_r == $past(bus_wr_data))
    else $error("pointer not loaded from first write byte");
  chk_cfg_write: assert property (
    data_wr && ptr_r == ADDR_CONFIG1_WRITE && !lock_r |=> cfg1_r == $past(bus_wr_data))
    else $error("config one write lost");
  chk_lock_hold: assert property (
    lock_r |=> lock_r && $stable(cfg1_r))
    else $error("locked config changed");
  chk_local_read: assert property (
    bus_rd_req && ptr_r == ADDR_LOCAL_RESULT |=> bus_rd_valid_r && bus_rd_data_r == $past(local_r))
    else $error("local read wrong");
  chk_result_ro: assert property (
    data_wr && ptr_r == ADDR_LOCAL_RESULT && !conv_in.valid |=> $stable(local_r))
    else $error("bus write reached result");
  chk_default_clamp: assert property (
    conv_ok && conv_in.channel == CH_LOCAL && !cfg1_r.range_select |=> local_r <= 8'h7f)
    else $error("default range not saturated");
  chk_ext_offset: assert property (
    conv_ok && conv_in.channel == CH_LOCAL && cfg1_r.range_select
    && conv_in.quarter_deg == 12'sh000 |=> local_r == 8'h40)
    else $error("offset binary zero wrong");
  chk_standby_quiet: assert property (
    cfg1_r.standby_select |=> alarm_pin_n_r && thermal_limit_output_n_r)
    else $error("alarm active in standby");
  chk_mask_all: assert property (
    !cfg1_r.pin_function_select && cfg1_r.alarm_mask_all |=> alarm_pin_n_r)
    else $error("masked alarm asserted");
  chk_high_freeze: assert property (
    freeze_r[0] && !rd_hi[0] |=> $stable(hi_r[0]))
    else $error("frozen high byte changed");
  // read path, encoding limits, standby and pin follow-up
  chk_rd_pulse: assert property (
    1'b1 |=> bus_rd_valid_r == $past(bus_rd_req))
    else $error("read answer not one cycle after strobe");
  chk_cfg_read: assert property (
    bus_rd_req && ptr_r == ADDR_CONFIG1_READ |=> bus_rd_data_r == $past(cfg1_r))
    else $error("config one read wrong");
  chk_view_read: assert property (
    bus_rd_req && ptr_r == ADDR_REMOTE1_HIGH && view2 |=> bus_rd_data_r == $past(hi_r[1]))
    else $error("view select read wrong channel");
  chk_ro_config: assert property (
    data_wr && ptr_r == ADDR_CONFIG1_READ |=> $stable(cfg1_r))
    else $error("write at read-only config changed it");
  chk_neg_zero: assert property (
    conv_ok && conv_in.channel == CH_LOCAL && !cfg1_r.range_select
    && conv_in.quarter_deg < 12'sh000 |=> local_r == 8'h00)
    else $error("negative default result not zero");
  chk_ext_clamp: assert property (
    conv_ok && conv_in.channel == CH_LOCAL && cfg1_r.range_select
    && conv_in.quarter_deg >= 12'sh300 |=> local_r == 8'hff)
    else $error("extended range not saturated");
  chk_standby_drop: assert property (
    conv_in.valid && cfg1_r.standby_select |=> $stable(local_r) && $stable(lo_r[0]))
    else $error("conversion taken in standby");
  chk_pend_release: assert property (
    rd_hi[0] && pend_v_r[0] && !conv_rem[0] |=> hi_r[0] == $past(pend_hi_r[0]))
    else $error("held high byte not released");
  chk_unfreeze: assert property (
    freeze_r[0] && rd_hi[0] && !bus_stop |=> !freeze_r[0])
    else $error("high byte still frozen after read");
  chk_thermal_pin: assert property (
    !cfg1_r.standby_select |=> thermal_limit_output_n_r == !$past(alarm_in.thermal_limit))
    else $error("thermal output does not follow limit");
  chk_mask_remote: assert property (
    !cfg1_r.standby_select && !cfg1_r.pin_function_select && !alarm_in.local_alarm
    && cfg1_r.first_remote_alarm_mask && cfg1_r.second_remote_alarm_mask |=> alarm_pin_n_r)
    else $error("masked remote alarm asserted");
endmodule
`default_nettype wire

// [tb/tsr_host_model.sv]
// host side model: drives the byte bus of the register bank
// assumes core_clk from the bench; requests change on the falling edge
`default_nettype none
module tsr_host_model (
  // clock
  input  wire logic       core_clk,
  // byte bus towards the register bank
  output logic            bus_wr_valid,
  output logic            bus_wr_first,
  output logic      [7:0] bus_wr_data,
  output logic            bus_rd_req,
  output logic            bus_stop,
  output logic            bus_rstart
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // idle bus
  // ****************************************
  initial
  begin
    bus_wr_valid = 1'b0;
    bus_wr_first = 1'b0;
    bus_wr_data  = 8'h00;
    bus_rd_req   = 1'b0;
    bus_stop     = 1'b0;
    bus_rstart   = 1'b0;
  end
  // one written byte, first marks the pointer byte
  task automatic put(input logic first, input logic [7:0] data);
    @(negedge core_clk);
    bus_wr_valid = 1'b1;
    bus_wr_first = first;
    bus_wr_data  = data;
    @(negedge core_clk);
    bus_wr_valid = 1'b0;
    bus_wr_data  = ~data;  // released lines never keep the old byte
  endtask
  // pointer byte, then data byte
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    put(1'b1, addr);
    put(1'b0, data);
  endtask
  // one byte read at the current pointer
  task automatic read_cur();
    @(negedge core_clk);
    bus_rd_req = 1'b1;
    @(negedge core_clk);
    bus_rd_req = 1'b0;
  endtask
  // end of transfer: stop between low and high read, or repeated start
  task automatic close(input logic use_stop);
    @(negedge core_clk);
    bus_stop   = use_stop;
    bus_rstart = ~use_stop;
    @(negedge core_clk);
    bus_stop   = 1'b0;
    bus_rstart = 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/tsr_regbank_tb.sv]
// self-checking bench of the temperature result register bank
// assumes tsr_pkg and the host model; reads are checked from a queue
`default_nettype none
module tsr_regbank_tb
  import tsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // signals
  // ****************************************
  logic       core_clk = 1'b0;
  logic       rst      = 1'b1;
  logic       bus_wr_valid, bus_wr_first, bus_rd_req, bus_stop, bus_rstart;
  logic [7:0] bus_wr_data, bus_rd_data_r;
  logic       bus_rd_valid_r, conv_halt_r, range_ext_r;
  logic       alarm_pin_n_r, thermal_limit_output_n_r;
  tsr_conv_s  conv_in;
  tsr_alarm_s alarm_in;
  logic [7:0] exp_q [$];          // expected read bytes, oldest first
  int         err_total       = 0;
  int         samples_checked = 0;
  int         cycles          = 0;
  logic [31:0] lfsr           = 32'hd794;
  localparam logic [7:0] RES_ADDR [5] = '{ADDR_LOCAL_RESULT, ADDR_REMOTE1_HIGH,
    ADDR_REMOTE1_LOW, ADDR_REMOTE2_HIGH, ADDR_REMOTE2_LOW};
  always #20 core_clk = ~core_clk;
  // ****************************************
  // design and host
  // ****************************************
  tsr_regbank dut_u (.core_clk(core_clk), .rst(rst), .bus_wr_valid(bus_wr_valid),
    .bus_wr_first(bus_wr_first), .bus_wr_data(bus_wr_data), .bus_rd_req(bus_rd_req),
    .bus_stop(bus_stop), .bus_rstart(bus_rstart), .bus_rd_data_r(bus_rd_data_r),
    .bus_rd_valid_r(bus_rd_valid_r), .conv_in(conv_in), .conv_halt_r(conv_halt_r),
    .range_ext_r(range_ext_r), .alarm_in(alarm_in), .alarm_pin_n_r(alarm_pin_n_r),
    .thermal_limit_output_n_r(thermal_limit_output_n_r));
  tsr_host_model host_u (.core_clk(core_clk), .bus_wr_valid(bus_wr_valid),
    .bus_wr_first(bus_wr_first), .bus_wr_data(bus_wr_data), .bus_rd_req(bus_rd_req),
    .bus_stop(bus_stop), .bus_rstart(bus_rstart));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  // expected {high, low} bytes of a quarter degree result
  function automatic logic [15:0] enc(input logic signed [11:0] q, input logic ext);
    int v;
    v = (q >>> 2) + (ext ? 64 : 0);
    if (v < 0) return 16'h0000;
    if (v > (ext ? 255 : 127)) return {(ext ? 8'hff : 8'h7f), 8'h00};
    return {v[7:0], q[1:0], 6'h00};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // note the expected byte, point and read
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    exp_q.push_back(exp);
    host_u.put(1'b1, addr);
    host_u.read_cur();
  endtask
  task automatic conv(input logic [1:0] ch, input logic signed [11:0] q);
    @(negedge core_clk);
    conv_in = '{valid: 1'b1, channel: ch, quarter_deg: q};
    @(negedge core_clk);
    conv_in.valid = 1'b0;
  endtask
  // random results on random channels, read back low before high
  task automatic run_convs(input logic ext);
    logic [15:0] e;
    logic [1:0]  ch;
    for (int i = 0; i < 12; i++)
    begin
      lfsr = nxt(lfsr);
      ch = (lfsr[13:12] == 2'h3) ? CH_LOCAL : lfsr[13:12];
      conv(ch, lfsr[11:0]);
      e = enc(lfsr[11:0], ext);
      if (ch == CH_LOCAL)
        rd(ADDR_LOCAL_RESULT, e[15:8]);
      else
      begin
        rd(ch == CH_REMOTE1 ? ADDR_REMOTE1_LOW : ADDR_REMOTE2_LOW, e[7:0]);
        rd(ch == CH_REMOTE1 ? ADDR_REMOTE1_HIGH : ADDR_REMOTE2_HIGH, e[15:8]);
      end
    end
  endtask
  task automatic finish_test();
    if (exp_q.size() != 0) err_total++;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ****************************************
  // read monitor and timeout
  // ****************************************
  always @(negedge core_clk)
    if (bus_rd_valid_r === 1'b1)
    begin
      if (exp_q.size() == 0) check(bus_rd_data_r, ~bus_rd_data_r);
      else check(bus_rd_data_r, exp_q.pop_front());
    end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      finish_test();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    tsr_cfg1_s cfg;
    logic      pin;
    conv_in  = '0;
    alarm_in = '0;
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    exp_q.push_back(RESULT_RESET);
    host_u.read_cur();
    foreach (RES_ADDR[i]) rd(RES_ADDR[i], RESULT_RESET);
    rd(ADDR_CONFIG1_READ, CONFIG1_RESET);
    check({4'h0, conv_halt_r, range_ext_r, alarm_pin_n_r, thermal_limit_output_n_r}, 8'h03);
    $display("test reset done");
    run_convs(1'b0);
    $display("test default range done");
    conv(CH_LOCAL, 12'sd100);
    host_u.write_reg(ADDR_LOCAL_RESULT, 8'h5a);
    host_u.write_reg(ADDR_CONFIG1_READ, 8'hff);
    rd(ADDR_LOCAL_RESULT, 8'h19);
    rd(ADDR_CONFIG1_READ, 8'h00);
    rd(8'h7e, UNMAPPED_READ);
    $display("test read only done");
    for (int i = 0; i < 16; i++)
    begin
      lfsr = nxt(lfsr);
      cfg = {lfsr[0], 1'b0, lfsr[1], 3'h0, lfsr[2], lfsr[3]};
      host_u.write_reg(ADDR_CONFIG1_WRITE, cfg);
      alarm_in = lfsr[8:4];
      repeat (2) @(negedge core_clk);
      pin = cfg.pin_function_select ? ~alarm_in.high_limit : ~(~cfg.alarm_mask_all &
        (alarm_in.local_alarm | alarm_in.remote1_alarm & ~cfg.first_remote_alarm_mask |
         alarm_in.remote2_alarm & ~cfg.second_remote_alarm_mask));
      check({7'h0, alarm_pin_n_r}, {7'h0, pin});
      check({7'h0, thermal_limit_output_n_r}, {7'h0, ~alarm_in.thermal_limit});
    end
    $display("test alarms done");
    host_u.write_reg(ADDR_CONFIG1_WRITE, 8'h40);
    alarm_in = '1;
    repeat (2) @(negedge core_clk);
    check({5'h0, conv_halt_r, alarm_pin_n_r, thermal_limit_output_n_r}, 8'h07);
    conv(CH_LOCAL, 12'sd200);
    rd(ADDR_LOCAL_RESULT, 8'h19);
    rd(ADDR_CONFIG1_READ, 8'h40);
    alarm_in = '0;
    $display("test standby done");
    host_u.write_reg(ADDR_CONFIG1_WRITE, 8'h04);
    @(negedge core_clk);
    check({7'h0, range_ext_r}, 8'h01);
    conv(CH_LOCAL, -12'sd40);
    rd(ADDR_LOCAL_RESULT, 8'h36);
    conv(CH_LOCAL, 12'sd0);
    rd(ADDR_LOCAL_RESULT, 8'h40);
    conv(CH_LOCAL, 12'sd800);
    rd(ADDR_LOCAL_RESULT, 8'hff);
    run_convs(1'b1);
    host_u.write_reg(ADDR_CONFIG1_WRITE, 8'h0c);
    conv(CH_REMOTE2, 12'sd401);
    rd(ADDR_REMOTE1_LOW, 8'h40);
    rd(ADDR_REMOTE1_HIGH, 8'ha4);
    $display("test extended range done");
    host_u.write_reg(ADDR_CONFIG1_WRITE, 8'h00);
    conv(CH_REMOTE1, 12'sd80);
    rd(ADDR_REMOTE1_LOW, 8'h00);
    host_u.close(1'b1);
    conv(CH_REMOTE1, 12'sd120);
    rd(ADDR_REMOTE1_HIGH, 8'h14);
    rd(ADDR_REMOTE1_HIGH, 8'h1e);
    rd(ADDR_REMOTE1_LOW, 8'h00);
    host_u.close(1'b0);
    conv(CH_REMOTE1, 12'sd160);
    rd(ADDR_REMOTE1_HIGH, 8'h28);
    $display("test freeze done");
    host_u.write_reg(ADDR_CONFIG2_LOCK, 8'h80);
    rd(ADDR_CONFIG2_LOCK, 8'h80);
    host_u.write_reg(ADDR_CONFIG1_WRITE, 8'h04);
    rd(ADDR_CONFIG1_READ, 8'h00);
    repeat (4) @(negedge core_clk);
    $display("test lock done");
    // second reset in mid-run clears lock, pointer and results
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    exp_q.push_back(RESULT_RESET);
    host_u.read_cur();
    rd(ADDR_CONFIG2_LOCK, 8'h00);
    rd(ADDR_REMOTE1_HIGH, RESULT_RESET);
    repeat (4) @(negedge core_clk);
    $display("test second reset done");
    finish_test();
  end
endmodule
`default_nettype wire
